/* File: hw/emcs_pkg.sv */
/*
 Shared constants and carriers of the MAC line configuration block.
 Assumes a single 50 MHz system clock domain.
*/
package emcs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MAINT = 8'h34;
  // ==========================================================
  // Control fields
  localparam int CTRL_RX_EN = 2;
  localparam int CTRL_TX_EN = 3;
  localparam int CTRL_MGMT_EN = 4;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_001c;
  // ==========================================================
  // Configuration fields
  localparam int CFG_SPEED = 0;
  localparam int CFG_FDX = 1;
  localparam int CFG_MUST1 = 4;
  localparam int CFG_LONG = 8;
  localparam int CFG_DIV_LO = 10;
  localparam int CFG_RETRY_TEST = 12;
  localparam int CFG_PAUSE_EN = 13;
  localparam int CFG_LEN_CHK = 16;
  localparam int CFG_HDX_RX = 18;
  localparam int CFG_IGN_FCS = 19;
  localparam logic [31:0] CFG_WMASK = 32'h000d_3d13;
  localparam logic [31:0] CFG_RESET = 32'h0000_0800;
  localparam int STAT_IDLE = 2;
  // ==========================================================
  // Frame limits
  localparam logic [11:0] MAX_STD = 12'd1518;
  localparam logic [11:0] MAX_LONG = 12'd2000;
  localparam logic [11:0] LEN_OVERHEAD = 12'd18;
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [11:0] LF_HI_POS = 12'd12;
  localparam logic [11:0] LF_LO_POS = 12'd13;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  // 512 bit times in 4-bit receive clock cycles
  localparam logic [6:0] TICKS_PER_QUANTUM = 7'd127;
  localparam logic [9:0] ONE_SLOT = 10'h001;
  localparam int MAX_EXP = 10;
  // ==========================================================
  // Management timing
  localparam real SYS_MHZ = 50.0;
  localparam real MDC_MAX_MHZ = 2.5;
  localparam int MDC_MIN_DIV = int'(SYS_MHZ / MDC_MAX_MHZ);
  localparam logic [5:0] HALF_DIV0 = 6'(MDC_MIN_DIV / 2);
  localparam logic [5:0] HALF_DIV1 = 6'd12;
  localparam logic [5:0] HALF_DIV2 = 6'd16;
  localparam logic [5:0] HALF_DIV3 = 6'd32;
  localparam logic [6:0] MGMT_BITS = 7'd64;
  localparam logic [6:0] MGMT_TA_BIT = 7'd46;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam int DESC_W = 13;
  localparam int FIFO_D = 16;
  // ==========================================================
  // Carriers
  typedef enum logic [1:0] {
    EMCS_MEDIA_MII = 2'b00,
    EMCS_MEDIA_RMII = 2'b01,
    EMCS_MEDIA_SMII = 2'b10
  } emcs_media_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic fcs_bad;
  } emcs_beat_t;

  typedef struct packed {
    logic [11:0] len;
    logic fcs_bad;
  } emcs_desc_t;
endpackage : emcs_pkg

/* File: hw/emcs_fifo.sv */
/*
 Parameterised valid/ready FIFO for frame descriptors.
 Assumes one clock; ce low freezes everything.
*/
`timescale 1ns/10ps
module emcs_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } emcs_fifo_st_t;

  emcs_fifo_st_t st_ff, nxt_st;
  logic [W-1:0] mem [D];
  logic full, empty, push, pop;

  assign empty = st_ff.wp == st_ff.rp;
  assign full = (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]) && (st_ff.wp[AW] != st_ff.rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_ff.rp[AW-1:0]];
  assign push = ce && in_valid && !full;
  assign pop = ce && out_ready && !empty;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset: only slots between pointers are read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st_ff.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : emcs_fifo

/* File: hw/emcs_mgmt.sv */
/*
 Serial management engine: MDC divider and 64-bit MDIO frame shifter.
 Assumes the caller starts a frame only while idle.
*/
`timescale 1ns/10ps
module emcs_mgmt
  import emcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Control
  input wire logic enable,
  input wire logic [1:0] div_code,
  input wire logic start,
  input wire logic [31:0] cmd,
  output logic idle,
  output logic [15:0] rd_data,
  // Pins
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);
  typedef enum logic {
    EMCS_M_IDLE = 1'b0,
    EMCS_M_RUN = 1'b1
  } emcs_mstate_t;

  typedef struct packed {
    emcs_mstate_t fsm;
    logic [5:0] div;
    logic [6:0] bits;
    logic [63:0] sh;
    logic rd;
    logic clk;
    logic [15:0] rdat;
  } emcs_mgmt_st_t;

  emcs_mgmt_st_t st_ff, nxt_st;
  logic [5:0] half;

  always_comb begin
    unique case (div_code)
      2'd0: half = HALF_DIV0;
      2'd1: half = HALF_DIV1;
      2'd2: half = HALF_DIV2; // R17
      2'd3: half = HALF_DIV3;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.fsm)
      EMCS_M_IDLE: begin
        nxt_st.clk = 1'b0;
        if (start && enable) begin
          nxt_st.fsm = EMCS_M_RUN;
          nxt_st.sh = {32'hffff_ffff, cmd};
          nxt_st.rd = cmd[29:28] == OP_READ;
          nxt_st.bits = '0;
          nxt_st.div = '0;
        end
      end
      EMCS_M_RUN: begin
        nxt_st.div = st_ff.div + 1'b1;
        if (st_ff.div == half - 1'b1) begin // R9
          nxt_st.div = '0;
          nxt_st.clk = !st_ff.clk;
          if (st_ff.clk) begin
            // Falling edge: advance to next bit
            nxt_st.sh = {st_ff.sh[62:0], 1'b0};
            nxt_st.bits = st_ff.bits + 1'b1;
            if (st_ff.bits == MGMT_BITS - 1'b1) begin
              nxt_st.fsm = EMCS_M_IDLE;
            end
          end else if (st_ff.rd && st_ff.bits > MGMT_TA_BIT) begin
            nxt_st.rdat = {st_ff.rdat[14:0], mdio_i};
          end
        end
        if (!enable) begin
          nxt_st.fsm = EMCS_M_IDLE; // R16
          nxt_st.clk = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign idle = st_ff.fsm == EMCS_M_IDLE; // R14
  assign mdc = st_ff.clk && enable; // R10 R16
  assign mdio_o = st_ff.sh[63];
  assign mdio_oe = enable && st_ff.fsm == EMCS_M_RUN && !(st_ff.rd && st_ff.bits >= MGMT_TA_BIT);
  assign rd_data = st_ff.rdat;
endmodule : emcs_mgmt

/* File: hw/emcs_top.sv */
/*
 MAC line configuration and status registers with the receive frame
 screening, pause, back-off and media controls they steer.
 Assumes a word-wide synchronous host port and byte beats from the
 receive decoder, all on mclk.
*/
// Notes on behaviour
// R1: With ignore_receive_checksum set, frames with a bad checksum are kept.
// R2: With ignore_receive_checksum set, the checksum error count does not move.
// R3: With half-duplex receive set, frames arriving during transmit are kept.
// R4: With length checking on, a frame shorter than its length field is dropped.
// R5: A length/type value that is a type never counts as a length error.
// R6: With pause honouring set, a received pause frame holds the transmitter.
// R7: With back-off test set, every back-off is exactly one slot.
// R8: With back-off test set, the pause count drops every receive clock tick.
// R9: The two-bit divider code picks the MDC division and resets to 2.
// R10: MDC toggles only during a management frame and stays at or below 2.5 MHz.
// R11: Frames above 1518 bytes are dropped, or above 2000 with long frames on.
// R12: Full duplex masks collision and carrier sense and allows receive in transmit.
// R13: The speed bit picks 10 or 100 Mbit/s, for reduced and serial media only.
// R14: The management idle status bit is one when no frame runs, and after reset.
// R15: Configuration bits 31 to 20 read zero and ignore writes.
// R16: With the management port disabled, MDIO floats and MDC stays low.
// R17: Divider code 2 divides by 32, keeping MDC near 1.56 MHz.
`timescale 1ns/10ps
module emcs_top
  import emcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Host register port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Receive byte stream
  input wire logic rx_valid,
  output logic rx_ready,
  input wire emcs_pkg::emcs_beat_t rx_beat,
  input wire logic rx_tick,
  // Accepted frame descriptors
  output logic desc_valid,
  input wire logic desc_ready,
  output emcs_pkg::emcs_desc_t desc_data,
  output logic [15:0] fcs_err_count,
  // Pause and transmit support
  input wire logic pause_rx_valid,
  input wire logic [15:0] pause_rx_quanta,
  output logic tx_hold,
  input wire logic tx_active,
  input wire logic mii_col,
  input wire logic mii_crs,
  output logic col_seen,
  output logic crs_seen,
  input wire logic backoff_req,
  input wire logic [3:0] backoff_attempt,
  output logic [9:0] backoff_slots,
  // Media
  input wire emcs_pkg::emcs_media_t media_sel,
  output logic speed_100,
  // Management pins
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);
  import emcs_pkg::*;

  typedef enum logic [1:0] {
    EMCS_RX_IDLE = 2'b00,
    EMCS_RX_RECV = 2'b01,
    EMCS_RX_DROP = 2'b11
  } emcs_rxstate_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] rdata;
    emcs_rxstate_t rx;
    logic [11:0] cnt;
    logic [15:0] lf;
    logic [15:0] fcs_cnt;
    logic [15:0] pause;
    logic [6:0] qdiv;
    logic [9:0] lfsr;
    logic [9:0] slots;
  } emcs_st_t;

  emcs_st_t st_ff, nxt_st;

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [9:0] exp_mask(input logic [3:0] n);
    logic [3:0] k;
    k = (n > 4'(MAX_EXP)) ? 4'(MAX_EXP) : n;
    return 10'((11'h001 << k) - 11'h001);
  endfunction : exp_mask

  logic wr_fire;
  logic beat_fire;
  logic rx_allowed;
  logic [11:0] meas;
  logic [11:0] max_len;
  logic too_long;
  logic len_err;
  logic fcs_reject;
  logic accept;
  logic push;
  logic push_ready;
  logic slot_tick;
  logic dec_tick;
  logic mgmt_idle;
  logic mgmt_start;
  logic [15:0] mgmt_rdata;
  emcs_desc_t push_desc;

  assign wr_fire = ce && reg_cs && reg_wr;
  assign mgmt_start = wr_fire && hit(reg_addr, OFF_MAINT);
  assign beat_fire = ce && rx_valid && rx_ready;

  // ==========================================================
  // Receive screening
  assign rx_allowed = st_ff.cfg[CFG_FDX] || st_ff.cfg[CFG_HDX_RX] || !tx_active; // R3 R12
  assign meas = (st_ff.cnt == CNT_MAX) ? CNT_MAX : st_ff.cnt + 12'h001;
  assign max_len = st_ff.cfg[CFG_LONG] ? MAX_LONG : MAX_STD;
  assign too_long = meas > max_len; // R11
  // Type values skip the check entirely
  assign len_err = st_ff.cfg[CFG_LEN_CHK] && (st_ff.lf < TYPE_MIN) // R5
    && (meas < LEN_OVERHEAD || 16'(meas - LEN_OVERHEAD) < st_ff.lf); // R4
  assign fcs_reject = rx_beat.fcs_bad && !st_ff.cfg[CFG_IGN_FCS]; // R1
  assign accept = !too_long && !len_err && !fcs_reject;
  assign push = beat_fire && rx_beat.last && st_ff.rx == EMCS_RX_RECV && accept;
  assign push_desc = '{len: meas, fcs_bad: rx_beat.fcs_bad};
  // Whole stream stalls while the descriptor queue is full
  assign rx_ready = push_ready && st_ff.ctrl[CTRL_RX_EN];

  // ==========================================================
  // Pause timing
  assign slot_tick = rx_tick && st_ff.qdiv == TICKS_PER_QUANTUM;
  assign dec_tick = st_ff.cfg[CFG_RETRY_TEST] ? rx_tick : slot_tick; // R8

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = '0;
    // ----------------------------------------------------------
    // Host port
    if (ce && reg_cs && !reg_wr) begin
      unique case (1'b1)
        hit(reg_addr, OFF_CTRL): nxt_st.rdata = st_ff.ctrl;
        hit(reg_addr, OFF_CFG): nxt_st.rdata = st_ff.cfg; // R15
        hit(reg_addr, OFF_STAT): nxt_st.rdata = 32'(mgmt_idle) << STAT_IDLE; // R14
        hit(reg_addr, OFF_MAINT): nxt_st.rdata = {16'h0000, mgmt_rdata};
        default: nxt_st.rdata = '0;
      endcase
    end
    if (wr_fire && hit(reg_addr, OFF_CTRL)) begin
      nxt_st.ctrl = reg_wdata & CTRL_WMASK;
    end
    if (wr_fire && hit(reg_addr, OFF_CFG)) begin
      nxt_st.cfg = reg_wdata & CFG_WMASK; // R15
    end
    // ----------------------------------------------------------
    // Receive frame tracking
    if (beat_fire) begin
      nxt_st.cnt = meas;
      if (st_ff.cnt == LF_HI_POS) begin
        nxt_st.lf[15:8] = rx_beat.data;
      end
      if (st_ff.cnt == LF_LO_POS) begin
        nxt_st.lf[7:0] = rx_beat.data;
      end
      unique case (st_ff.rx)
        EMCS_RX_IDLE: begin
          nxt_st.rx = rx_allowed ? EMCS_RX_RECV : EMCS_RX_DROP; // R3 R12
          nxt_st.cnt = 12'h001;
          nxt_st.lf = '0;
        end
        EMCS_RX_RECV: begin
          if (!rx_allowed) begin
            nxt_st.rx = EMCS_RX_DROP;
          end
        end
        EMCS_RX_DROP: begin
          nxt_st.rx = EMCS_RX_DROP;
        end
        default: nxt_st.rx = EMCS_RX_IDLE;
      endcase
      if (rx_beat.last) begin
        nxt_st.rx = EMCS_RX_IDLE;
        if (st_ff.rx != EMCS_RX_DROP && rx_beat.fcs_bad && !st_ff.cfg[CFG_IGN_FCS]) begin
          nxt_st.fcs_cnt = st_ff.fcs_cnt + 16'h0001; // R2
        end
      end
    end
    if (!st_ff.ctrl[CTRL_RX_EN]) begin
      nxt_st.rx = EMCS_RX_IDLE;
    end
    // ----------------------------------------------------------
    // Pause count
    if (ce && rx_tick) begin
      nxt_st.qdiv = slot_tick ? '0 : st_ff.qdiv + 7'h01;
    end
    if (ce && dec_tick && st_ff.pause != '0) begin
      nxt_st.pause = st_ff.pause - 16'h0001;
    end
    if (ce && pause_rx_valid && st_ff.cfg[CFG_PAUSE_EN]) begin
      nxt_st.pause = pause_rx_quanta; // R6
    end
    if (!st_ff.cfg[CFG_PAUSE_EN]) begin
      nxt_st.pause = '0;
    end
    // ----------------------------------------------------------
    // Back-off draw
    if (ce) begin
      nxt_st.lfsr = {st_ff.lfsr[8:0], st_ff.lfsr[9] ^ st_ff.lfsr[6]};
    end
    if (ce && backoff_req) begin
      nxt_st.slots = st_ff.cfg[CFG_RETRY_TEST] ? ONE_SLOT // R7
        : st_ff.lfsr & exp_mask(backoff_attempt);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.cfg <= CFG_RESET; // R9
      st_ff.lfsr <= 10'h001;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = st_ff.rdata;
  assign fcs_err_count = st_ff.fcs_cnt;
  assign tx_hold = st_ff.cfg[CFG_PAUSE_EN] && st_ff.pause != '0; // R6
  assign col_seen = mii_col && !st_ff.cfg[CFG_FDX]; // R12
  assign crs_seen = mii_crs && !st_ff.cfg[CFG_FDX]; // R12
  assign backoff_slots = st_ff.slots;
  // Plain MII takes its rate from the PHY clock
  assign speed_100 = st_ff.cfg[CFG_SPEED] && media_sel != EMCS_MEDIA_MII; // R13

  // ==========================================================
  // Descriptor queue
  emcs_fifo #(
    .W(DESC_W),
    .D(FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_desc),
    .out_valid(desc_valid),
    .out_ready(desc_ready),
    .out_data(desc_data)
  );

  // ==========================================================
  // Management engine
  emcs_mgmt u_mgmt (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .enable(st_ff.ctrl[CTRL_MGMT_EN]), // R16
    .div_code(st_ff.cfg[CFG_DIV_LO +: 2]), // R9
    .start(mgmt_start && mgmt_idle),
    .cmd(reg_wdata),
    .idle(mgmt_idle),
    .rd_data(mgmt_rdata),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe)
  );
endmodule : emcs_top

/* File: bench/emcs_chk.sv */
/*
 Port checker of the MAC line configuration block.
 Assumes it is bound to emcs_top and shares its single clock.
*/
`timescale 1ns/10ps
module emcs_chk
  import emcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Host port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Line side
  input wire logic mii_col,
  input wire logic col_seen,
  input wire logic crs_seen,
  input wire logic tx_hold,
  input wire logic backoff_req,
  input wire logic [3:0] backoff_attempt,
  input wire logic [9:0] backoff_slots,
  input wire logic [15:0] fcs_err_count,
  input wire emcs_pkg::emcs_media_t media_sel,
  input wire logic speed_100,
  input wire logic mdc,
  input wire logic mdio_oe
);
  import emcs_pkg::*;
  // ==========================================================
  // Register shadow
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
  } emcs_shadow_t;
  emcs_shadow_t sh_ff;
  emcs_shadow_t nxt_sh;
  always_comb begin
    nxt_sh = sh_ff;
    if (ce && reg_cs && reg_wr && reg_addr == OFF_CTRL) begin
      nxt_sh.ctrl = reg_wdata & CTRL_WMASK;
    end
    if (ce && reg_cs && reg_wr && reg_addr == OFF_CFG) begin
      nxt_sh.cfg = reg_wdata & CFG_WMASK;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sh_ff <= '{ctrl: 32'h0000_0000, cfg: CFG_RESET};
    end else begin
      sh_ff <= nxt_sh;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  fdx_mask_a: assert property (sh_ff.cfg[CFG_FDX] |-> !col_seen && !crs_seen)
    else $error("collision or carrier passed in full duplex");
  hdx_col_a: assert property (!sh_ff.cfg[CFG_FDX] && mii_col |-> col_seen)
    else $error("collision lost in half duplex");
  speed_sel_a: assert property (speed_100 == (sh_ff.cfg[CFG_SPEED] && media_sel != EMCS_MEDIA_MII))
    else $error("speed output wrong");
  cfg_read_a: assert property (ce && reg_cs && !reg_wr && reg_addr == OFF_CFG
    |=> reg_rdata == $past(sh_ff.cfg))
    else $error("configuration read wrong");
  stat_read_a: assert property (ce && reg_cs && !reg_wr && reg_addr == OFF_STAT
    |=> reg_rdata[31:3] == 29'h0 && reg_rdata[1:0] == 2'h0)
    else $error("status spare bits set");
  mgmt_off_a: assert property (!sh_ff.ctrl[CTRL_MGMT_EN] [*2] |-> !mdc && !mdio_oe)
    else $error("management pins active while disabled");
  mdc_slow_a: assert property (disable iff (!nrst || !sh_ff.ctrl[CTRL_MGMT_EN])
    $changed(mdc) |=> $stable(mdc) [*8])
    else $error("management clock too fast");
  pause_off_a: assert property (!sh_ff.cfg[CFG_PAUSE_EN] |-> !tx_hold)
    else $error("transmit held without pause honouring");
  slot_one_a: assert property (ce && backoff_req && sh_ff.cfg[CFG_RETRY_TEST]
    |=> backoff_slots == ONE_SLOT)
    else $error("test back-off not one slot");
  fcs_hold_a: assert property (sh_ff.cfg[CFG_IGN_FCS] [*2] |-> $stable(fcs_err_count))
    else $error("checksum count moved while ignored");
  cfg_rd_c: cover property (ce && reg_cs && !reg_wr && reg_addr == OFF_CFG);
  hold_c: cover property (tx_hold);
  slot_c: cover property (backoff_req && sh_ff.cfg[CFG_RETRY_TEST]);
  mdc_c: cover property ($rose(mdc));
endmodule : emcs_chk
bind emcs_top emcs_chk chk_i (.mclk, .nrst, .ce, .reg_cs, .reg_wr, .reg_addr, .reg_wdata,
  .reg_rdata, .mii_col, .col_seen, .crs_seen, .tx_hold, .backoff_req, .backoff_attempt,
  .backoff_slots, .fcs_err_count, .media_sel, .speed_100, .mdc, .mdio_oe);

/* File: bench/emcs_phy.sv */
/*
 Management side of the line partner: answers a read frame.
 Assumes the line is pulled up by the bench when nobody drives it.
*/
`timescale 1ns/10ps
module emcs_phy #(
  parameter logic [15:0] RD_VAL = 16'ha5c3
) (
  // Management pins
  input wire logic mdc,
  input wire logic mac_oe,
  input wire logic mac_o,
  output logic phy_o,
  output logic phy_oe,
  // Last 32 bits driven by the MAC
  output logic [31:0] mac_bits
);
  int n = 0;
  initial begin
    phy_o = 1'b0;
    phy_oe = 1'b0;
  end
  // Frame start restarts the bit count
  always @(posedge mac_oe) n = 0;
  always @(posedge mdc) n <= n + 1;
  // Capture what the MAC drives, so its command bits can be checked
  always @(posedge mdc) begin
    if (mac_oe) begin
      mac_bits <= {mac_bits[30:0], mac_o};
    end
  end
  // Drive turnaround low then data, changed on falling edge only
  always @(negedge mdc) begin
    phy_oe <= !mac_oe && n >= 47 && n <= 63;
    phy_o <= (n >= 48 && n <= 63) ? RD_VAL[63 - n] : 1'b0;
  end
endmodule : emcs_phy

/* File: bench/emcs_tb.sv */
/*
 Self-checking bench of the MAC line configuration block.
 Assumes the partner model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module tb;
  import emcs_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic reg_cs = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic rx_valid = 1'b0;
  logic rx_ready;
  emcs_beat_t rx_beat = '0;
  logic rx_tick = 1'b0;
  logic desc_valid;
  logic desc_ready = 1'b0;
  emcs_desc_t desc_data;
  logic [15:0] fcs_err_count;
  logic pause_rx_valid = 1'b0;
  logic [15:0] pause_rx_quanta = 16'h0;
  logic tx_hold;
  logic tx_active = 1'b0;
  logic mii_col = 1'b0;
  logic mii_crs = 1'b0;
  logic col_seen;
  logic crs_seen;
  logic backoff_req = 1'b0;
  logic [3:0] backoff_attempt = 4'h0;
  logic [9:0] backoff_slots;
  emcs_media_t media_sel = EMCS_MEDIA_MII;
  logic speed_100;
  logic mdc;
  logic mdio_i;
  logic mdio_o;
  logic mdio_oe;
  logic phy_o;
  logic phy_oe;
  logic [31:0] mac_bits;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  longint t0;
  emcs_top uut (.mclk, .nrst, .ce, .reg_cs, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .rx_valid, .rx_ready, .rx_beat, .rx_tick, .desc_valid, .desc_ready, .desc_data,
    .fcs_err_count, .pause_rx_valid, .pause_rx_quanta, .tx_hold, .tx_active, .mii_col,
    .mii_crs, .col_seen, .crs_seen, .backoff_req, .backoff_attempt, .backoff_slots,
    .media_sel, .speed_100, .mdc, .mdio_i, .mdio_o, .mdio_oe);
  emcs_phy phy (.mdc(mdc), .mac_oe(mdio_oe), .mac_o(mdio_o), .phy_o(phy_o), .phy_oe(phy_oe),
    .mac_bits(mac_bits));
  // Pulled-up management line
  assign mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_cs <= 1'b1;
    reg_wr <= wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_cs <= 1'b0;
    #1;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic frame(input int len, input logic [15:0] fld, input logic bad);
    for (int i = 0; i < len; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_beat.data <= (i == 12) ? fld[15:8] : (i == 13) ? fld[7:0] : 8'(i);
      rx_beat.last <= (i == len - 1);
      rx_beat.fcs_bad <= bad;
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : frame
  task automatic take(input logic ok, input int len);
    chk(desc_valid, ok);
    if (ok) begin
      chk(desc_data.len, len);
      @(posedge mclk);
      desc_ready <= 1'b1;
      @(posedge mclk);
      desc_ready <= 1'b0;
    end
    #1;
  endtask : take
  task automatic rxcase(input logic [31:0] c, input int len, input logic [15:0] fld,
    input logic bad, input logic ok);
    acc(1'b1, OFF_CFG, c);
    frame(len, fld, bad);
    if (ok) begin
      chk(desc_data.fcs_bad, bad);
    end
    take(ok, len);
  endtask : rxcase
  task automatic pulse(input int kind, input logic [15:0] v, input int n);
    repeat (n) begin
      @(posedge mclk);
      rx_tick <= (kind == 0);
      pause_rx_valid <= (kind == 1);
      pause_rx_quanta <= v;
      backoff_req <= (kind == 2);
      backoff_attempt <= v[3:0];
      @(posedge mclk);
      rx_tick <= 1'b0;
      pause_rx_valid <= 1'b0;
      backoff_req <= 1'b0;
    end
    #1;
  endtask : pulse
  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd(OFF_CFG, 32'h0000_0800);
    rd(OFF_STAT, 32'h0000_0004);
    rd(8'h10, 32'h0);
    acc(1'b1, OFF_CFG, 32'hffff_ffff);
    rd(OFF_CFG, 32'h000d_3d13);
    for (int m = 0; m < 3; m++) begin
      media_sel <= emcs_media_t'(m);
      @(posedge mclk);
      #1;
      chk(speed_100, m != 0);
    end
    mii_col <= 1'b1;
    mii_crs <= 1'b1;
    #1;
    chk({col_seen, crs_seen}, 0);
    acc(1'b1, OFF_CFG, 32'h0000_0810);
    chk({col_seen, crs_seen}, 3);
    $display("register test done");
    acc(1'b1, OFF_CTRL, 32'h0000_001c);
    rxcase(32'h0000_0810, 1518, 16'h0800, 1'b0, 1'b1);
    rxcase(32'h0000_0810, 1519, 16'h0800, 1'b0, 1'b0);
    rxcase(32'h0000_0910, 2000, 16'h0800, 1'b0, 1'b1);
    rxcase(32'h0000_0910, 2001, 16'h0800, 1'b0, 1'b0);
    rxcase(32'h0000_0810, 64, 16'h0800, 1'b1, 1'b0);
    chk(fcs_err_count, 1);
    rxcase(32'h0008_0810, 64, 16'h0800, 1'b1, 1'b1);
    chk(fcs_err_count, 1);
    rxcase(32'h0001_0810, 64, 16'h002e, 1'b0, 1'b1);
    rxcase(32'h0001_0810, 64, 16'h002f, 1'b0, 1'b0);
    rxcase(32'h0001_0810, 64, 16'h0600, 1'b0, 1'b1);
    tx_active <= 1'b1;
    rxcase(32'h0000_0810, 64, 16'h0800, 1'b0, 1'b0);
    rxcase(32'h0004_0810, 64, 16'h0800, 1'b0, 1'b1);
    rxcase(32'h0000_0812, 64, 16'h0800, 1'b0, 1'b1);
    tx_active <= 1'b0;
    $display("receive test done");
    acc(1'b1, OFF_CFG, 32'h0000_0810);
    repeat (16) frame(20, 16'h0800, 1'b0);
    chk(rx_ready, 0);
    repeat (16) take(1'b1, 20);
    chk(desc_valid, 0);
    $display("buffer test done");
    acc(1'b1, OFF_CFG, 32'h0000_2810);
    pulse(1, 16'h0001, 1);
    chk(tx_hold, 1);
    pulse(0, 16'h0, 127);
    chk(tx_hold, 1);
    pulse(0, 16'h0, 1);
    chk(tx_hold, 0);
    acc(1'b1, OFF_CFG, 32'h0000_3810);
    pulse(1, 16'h0003, 1);
    pulse(0, 16'h0, 2);
    chk(tx_hold, 1);
    pulse(0, 16'h0, 1);
    chk(tx_hold, 0);
    pulse(2, 16'h0005, 1);
    chk(backoff_slots, 1);
    acc(1'b1, OFF_CFG, 32'h0000_0810);
    pulse(2, 16'h0000, 1);
    chk(backoff_slots, 0);
    $display("pause and back-off test done");
    acc(1'b1, OFF_MAINT, 32'h6802_0000);
    @(posedge mdc);
    t0 = $time;
    @(negedge mdc);
    chk(32'(($time - t0) / 20), 16);
    rd(OFF_STAT, 32'h0);
    repeat (60) begin
      repeat (100) @(posedge mclk);
      acc(1'b0, OFF_STAT, 32'h0);
      if (reg_rdata[STAT_IDLE] === 1'b1) break;
    end
    rd(OFF_STAT, 32'h0000_0004);
    acc(1'b0, OFF_MAINT, 32'h0);
    chk(reg_rdata[15:0], 16'ha5c3);
    chk(mac_bits, 32'hffff_da00);
    acc(1'b1, OFF_MAINT, 32'h5802_0000);
    repeat (20) @(posedge mclk);
    #1;
    chk({mdc, mdio_oe}, 3);
    acc(1'b1, OFF_CTRL, 32'h0000_000c);
    repeat (2) @(posedge mclk);
    #1;
    chk({mdc, mdio_oe}, 0);
    rd(OFF_STAT, 32'h0000_0004);
    $display("management test done");
    give_verdict();
  end
endmodule : tb
